// ===== oag_pkg.sv
package oag_pkg;

  // Addressing modes after opcode decode, seventeen in all
  typedef enum logic [4:0] {
    AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX0, AM_IDX_S, AM_IDX_L, AM_IND_S, AM_IND_L,
    AM_INDX_S, AM_INDX_L, AM_REL_D, AM_REL_I, AM_BIT_D, AM_BIT_I, AM_BITREL_D, AM_BITREL_I
  } oag_mode_e;

  // Instruction classes that limit the accepted modes
  typedef enum logic [2:0] {CL_ALU, CL_RMW, CL_REG, CL_BRANCH, CL_BIT} oag_class_e;

  localparam int MODE_COUNT = 17;
  localparam logic [7:0] NO_PREBYTE = 8'h00;
  localparam logic [7:0] SECOND_INDEX_PREBYTE = 8'h90;
  localparam logic [7:0] SECOND_INDIRECT_PREBYTE = 8'h91;
  localparam logic [7:0] INDIRECT_PREBYTE = 8'h92;
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] SHORT_INDEXED_TOP = 16'h01fe;
  localparam logic [2:0] OPCODE_BYTES = 3'h1;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Request from the core: decoded mode, class, prebyte, index registers, address after opcode
  typedef struct packed {
    oag_mode_e mode;
    oag_class_e cls;
    logic [7:0] prebyte;
    logic [7:0] ind_reg_one;
    logic [7:0] ind_reg_two;
    logic [15:0] next_addr;
  } oag_req_s;

  // Result handed back to the core
  typedef struct packed {
    oag_mode_e mode;
    logic use_two;
    logic mode_err;
    logic [2:0] length;
    logic [7:0] operand;
    logic [15:0] eff_addr;
    logic [15:0] branch_target;
  } oag_res_s;

  // Bytes that follow the opcode for each mode
  function automatic logic [1:0] oag_extra(input oag_mode_e m);
    unique case (m)
      AM_INH, AM_IDX0: oag_extra = 2'h0;
      AM_DIR_L, AM_IDX_L, AM_BITREL_D, AM_BITREL_I: oag_extra = 2'h2;
      default: oag_extra = 2'h1;
    endcase
  endfunction

  // Prebyte conversion of the opcode's own mode
  function automatic oag_mode_e oag_convert(input oag_mode_e m, input logic [7:0] pre);
    oag_convert = m;
    if (pre == INDIRECT_PREBYTE || pre == SECOND_INDIRECT_PREBYTE) begin
      unique case (m)
        AM_DIR_S: oag_convert = AM_IND_S;
        AM_DIR_L: oag_convert = AM_IND_L;
        AM_IDX_S: oag_convert = AM_INDX_S;
        AM_IDX_L: oag_convert = AM_INDX_L;
        AM_REL_D: oag_convert = AM_REL_I;
        AM_BIT_D: oag_convert = AM_BIT_I;
        AM_BITREL_D: oag_convert = AM_BITREL_I;
        default: oag_convert = m;
      endcase
    end
  endfunction

  // Modes that read a pointer from page zero
  function automatic logic oag_has_ptr(input oag_mode_e m);
    oag_has_ptr = m inside {AM_IND_S, AM_IND_L, AM_INDX_S, AM_INDX_L, AM_REL_I, AM_BIT_I, AM_BITREL_I};
  endfunction

  // Word-sized pointers
  function automatic logic oag_word_ptr(input oag_mode_e m);
    oag_word_ptr = m inside {AM_IND_L, AM_INDX_L};
  endfunction

  // Relative target from an already advanced program counter
  function automatic logic [15:0] oag_rel(input logic [15:0] pc, input logic [7:0] off);
    oag_rel = pc + {{8{off[7]}}, off};
  endfunction

endpackage

// ===== oag_core.sv
`timescale 1ns/100ps
// What this block does
// RULE1: Seventeen addressing modes in inherent, immediate, direct, indexed, indirect, relative, bit groups.
// RULE2: Short forms reach page zero only; long forms reach the full 64 Kbyte space. Short indexed forms here reach up to 1FE.
// RULE3: Read-modify-write instructions accept only short addressing forms.
// RULE4: Inherent instructions are exactly one byte, opcode only.
// RULE5: Immediate instructions are two bytes; second byte is the operand itself.
// RULE6: Short direct uses the byte after the opcode as address 00 to FF.
// RULE7: Long direct uses two bytes after the opcode as a 16-bit address.
// RULE8: Indexed address is the unsigned sum of index register and offset.
// RULE9: No-offset indexed has no following byte; index alone addresses 00 to FF.
// RULE10: No-offset indexed with second index register is one byte longer.
// RULE11: Short indexed sum reaches 00 to 1FE without eight-bit wrap.
// RULE12: Long indexed adds a 16-bit offset to the index register.
// RULE13: Indirect modes read the operand address from a page-zero pointer.
// RULE14: Short indirect uses a byte pointer, reaching 00 to FF, one byte after opcode.
// RULE15: Indirect indexed address is index plus pointer fetched from page zero.
// RULE16: Short indirect indexed reaches 00 to 1FE; long form reaches 64 Kbyte.
// RULE17: Relative targets use the counter already past the branch instruction.
// RULE18: Load, compare, bit compare, logical and arithmetic take all memory forms.
// RULE19: Those same instructions also take immediate operands.
// RULE20: Register operations have inherent forms.
// RULE21: Prebyte 90 selects the second index register.
// RULE22: Prebyte 92 turns direct and indexed forms into indirect forms.
// RULE23: Prebyte 91 turns first-index indirect indexed into second-index form.
// RULE24: Relative offset is an 8-bit signed two's-complement value.
// RULE25: 16-bit values take the high byte from the lower address.
// RULE26: Long pointers come from two consecutive page-zero locations; a pointer at FF takes its second byte from 0100.
module oag_core
  import oag_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic START_IN,
  input wire oag_req_s REQ_IN,
  input wire logic [7:0] MEM_DATA_IN,
  output logic MEM_RD_OUT,
  output logic [15:0] MEM_ADDR_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output oag_res_s RES_OUT
);

  typedef enum logic [2:0] {S_IDLE, S_OP1, S_OP2, S_PT1, S_PT2, S_FORM} oag_state_e;

  oag_state_e st_r, st_nxt;
  logic ph_r, ph_nxt;
  logic rd_r, rd_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] b1_r, b1_nxt;
  logic [7:0] b2_r, b2_nxt;
  logic [7:0] p1_r, p1_nxt;
  logic [7:0] p2_r, p2_nxt;
  oag_mode_e mode_r, mode_nxt;
  logic two_r, two_nxt;
  logic err_r, err_nxt;
  logic pre_r, pre_nxt;
  logic [7:0] ix_r, ix_nxt;
  logic [15:0] base_r, base_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  oag_res_s res_r, res_nxt;

  // Mode of the incoming request after the prebyte
  oag_mode_e req_mode;
  logic req_two;
  logic req_ok;

  // Legality of class, mode and prebyte combinations
  function automatic logic oag_legal(input oag_class_e c, input oag_mode_e m, input logic [7:0] pre);
    logic mode_ok;
    logic pre_ok;
    mode_ok = 1'b0;
    pre_ok = 1'b0;
    unique case (c)
      // RULE18: all memory forms
      // RULE19: immediate accepted
      CL_ALU: mode_ok = m inside {AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX0, AM_IDX_S, AM_IDX_L,
                                   AM_IND_S, AM_IND_L, AM_INDX_S, AM_INDX_L};
      // RULE3: short forms only
      CL_RMW: mode_ok = m inside {AM_INH, AM_DIR_S, AM_IDX0, AM_IDX_S, AM_IND_S, AM_INDX_S};
      // RULE20: register ops inherent
      CL_REG: mode_ok = (m == AM_INH);
      CL_BRANCH: mode_ok = m inside {AM_REL_D, AM_REL_I};
      CL_BIT: mode_ok = m inside {AM_BIT_D, AM_BIT_I, AM_BITREL_D, AM_BITREL_I};
    endcase
    unique case (pre)
      NO_PREBYTE: pre_ok = 1'b1;
      // RULE21: second index forms
      SECOND_INDEX_PREBYTE: pre_ok = m inside {AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX0, AM_IDX_S,
                                                AM_IDX_L};
      // RULE22: indirect conversions
      INDIRECT_PREBYTE: pre_ok = m inside {AM_DIR_S, AM_DIR_L, AM_IDX_S, AM_IDX_L, AM_REL_D, AM_BIT_D,
                                            AM_BITREL_D};
      // RULE23: second index indirect
      SECOND_INDIRECT_PREBYTE: pre_ok = m inside {AM_IDX_S, AM_IDX_L};
      default: pre_ok = 1'b0;
    endcase
    oag_legal = mode_ok && pre_ok;
  endfunction

  // Request decode with prebyte applied
  always_comb begin
    // RULE1: seventeen mode decode
    req_mode = oag_convert(REQ_IN.mode, REQ_IN.prebyte);
    // RULE21: second index select
    req_two = (REQ_IN.prebyte == SECOND_INDEX_PREBYTE) || (REQ_IN.prebyte == SECOND_INDIRECT_PREBYTE);
    req_ok = oag_legal(REQ_IN.cls, REQ_IN.mode, REQ_IN.prebyte);
  end

  // Fetch sequencer and address formation
  always_comb begin
    logic [15:0] pc_next;
    logic [15:0] ix16;
    pc_next = ADDR_RST;
    ix16 = ADDR_RST;
    st_nxt = st_r;
    ph_nxt = 1'b0;
    rd_nxt = 1'b0;
    addr_nxt = addr_r;
    b1_nxt = b1_r;
    b2_nxt = b2_r;
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    mode_nxt = mode_r;
    two_nxt = two_r;
    err_nxt = err_r;
    pre_nxt = pre_r;
    ix_nxt = ix_r;
    base_nxt = base_r;
    done_nxt = 1'b0;
    res_nxt = res_r;
    unique case (st_r)
      S_IDLE: begin
        if (START_IN) begin
          mode_nxt = req_mode;
          two_nxt = req_two;
          err_nxt = !req_ok;
          pre_nxt = (REQ_IN.prebyte != NO_PREBYTE);
          ix_nxt = req_two ? REQ_IN.ind_reg_two : REQ_IN.ind_reg_one;
          base_nxt = REQ_IN.next_addr;
          // RULE4: inherent needs no fetch
          // RULE9: no-offset indexed needs no fetch
          if (!req_ok || oag_extra(req_mode) == 2'h0) begin
            st_nxt = S_FORM;
          end else begin
            st_nxt = S_OP1;
            rd_nxt = 1'b1;
            addr_nxt = REQ_IN.next_addr;
          end
        end
      end
      S_OP1: begin
        if (!ph_r) begin
          ph_nxt = 1'b1;
        end else begin
          b1_nxt = MEM_DATA_IN;
          if (oag_extra(mode_r) == 2'h2) begin
            // RULE7: second address byte
            st_nxt = S_OP2;
            rd_nxt = 1'b1;
            addr_nxt = base_r + 16'h0001;
          end else if (oag_has_ptr(mode_r)) begin
            // RULE13: pointer in page zero
            st_nxt = S_PT1;
            rd_nxt = 1'b1;
            addr_nxt = {PAGE_ZERO_HI, MEM_DATA_IN};
          end else begin
            st_nxt = S_FORM;
          end
        end
      end
      S_OP2: begin
        if (!ph_r) begin
          ph_nxt = 1'b1;
        end else begin
          b2_nxt = MEM_DATA_IN;
          if (oag_has_ptr(mode_r)) begin
            st_nxt = S_PT1;
            rd_nxt = 1'b1;
            addr_nxt = {PAGE_ZERO_HI, b1_r};
          end else begin
            st_nxt = S_FORM;
          end
        end
      end
      S_PT1: begin
        if (!ph_r) begin
          ph_nxt = 1'b1;
        end else begin
          p1_nxt = MEM_DATA_IN;
          if (oag_word_ptr(mode_r)) begin
            // RULE26: next pointer location
            st_nxt = S_PT2;
            rd_nxt = 1'b1;
            addr_nxt = {PAGE_ZERO_HI, b1_r} + 16'h0001;
          end else begin
            st_nxt = S_FORM;
          end
        end
      end
      S_PT2: begin
        if (!ph_r) begin
          ph_nxt = 1'b1;
        end else begin
          p2_nxt = MEM_DATA_IN;
          st_nxt = S_FORM;
        end
      end
      S_FORM: begin
        // RULE17: counter past the instruction
        pc_next = base_r + {14'h0000, oag_extra(mode_r)};
        ix16 = {PAGE_ZERO_HI, ix_r};
        res_nxt.mode = mode_r;
        res_nxt.use_two = two_r;
        res_nxt.mode_err = err_r;
        // RULE10: prebyte adds one byte
        res_nxt.length = OPCODE_BYTES + {2'h0, pre_r} + {1'b0, oag_extra(mode_r)};
        res_nxt.operand = BYTE_RST;
        res_nxt.eff_addr = ADDR_RST;
        res_nxt.branch_target = pc_next;
        unique case (mode_r)
          AM_INH: res_nxt.eff_addr = ADDR_RST;
          // RULE5: operand used directly
          AM_IMM: begin
            res_nxt.operand = b1_r;
            res_nxt.eff_addr = base_r;
          end
          // RULE6: short direct page zero
          // RULE2: short forms in page zero
          AM_DIR_S, AM_BIT_D: res_nxt.eff_addr = {PAGE_ZERO_HI, b1_r};
          // RULE25: high byte first
          AM_DIR_L: res_nxt.eff_addr = {b1_r, b2_r};
          // RULE8: index alone, no offset added
          AM_IDX0: res_nxt.eff_addr = ix16;
          // RULE11: nine-bit sum kept
          AM_IDX_S: res_nxt.eff_addr = {PAGE_ZERO_HI, b1_r} + ix16;
          // RULE12: long offset plus index
          AM_IDX_L: res_nxt.eff_addr = {b1_r, b2_r} + ix16;
          // RULE14: byte pointer page zero
          AM_IND_S, AM_BIT_I: res_nxt.eff_addr = {PAGE_ZERO_HI, p1_r};
          AM_IND_L: res_nxt.eff_addr = {p1_r, p2_r};
          // RULE15: pointer plus index
          // RULE16: short reaches 1FE
          AM_INDX_S: res_nxt.eff_addr = {PAGE_ZERO_HI, p1_r} + ix16;
          AM_INDX_L: res_nxt.eff_addr = {p1_r, p2_r} + ix16;
          // RULE24: signed offset add
          AM_REL_D: res_nxt.branch_target = oag_rel(pc_next, b1_r);
          AM_REL_I: res_nxt.branch_target = oag_rel(pc_next, p1_r);
          AM_BITREL_D: begin
            res_nxt.eff_addr = {PAGE_ZERO_HI, b1_r};
            res_nxt.branch_target = oag_rel(pc_next, b2_r);
          end
          AM_BITREL_I: begin
            res_nxt.eff_addr = {PAGE_ZERO_HI, p1_r};
            res_nxt.branch_target = oag_rel(pc_next, b2_r);
          end
        endcase
        done_nxt = 1'b1;
        st_nxt = S_IDLE;
      end
    endcase
    busy_nxt = (st_nxt != S_IDLE);
  end

  // State registers
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= S_IDLE;
      ph_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= ADDR_RST;
      b1_r <= BYTE_RST;
      b2_r <= BYTE_RST;
      p1_r <= BYTE_RST;
      p2_r <= BYTE_RST;
      mode_r <= AM_INH;
      two_r <= 1'b0;
      err_r <= 1'b0;
      pre_r <= 1'b0;
      ix_r <= BYTE_RST;
      base_r <= ADDR_RST;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      res_r <= '0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      b1_r <= b1_nxt;
      b2_r <= b2_nxt;
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      mode_r <= mode_nxt;
      two_r <= two_nxt;
      err_r <= err_nxt;
      pre_r <= pre_nxt;
      ix_r <= ix_nxt;
      base_r <= base_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      res_r <= res_nxt;
    end
  end

  // Outputs straight from flops
  assign MEM_RD_OUT = rd_r;
  assign MEM_ADDR_OUT = addr_r;
  assign BUSY_OUT = busy_r;
  assign DONE_OUT = done_r;
  assign RES_OUT = res_r;

  // Checks on the memory reads and the formed results
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  logic take_w;
  assign take_w = START_IN && (st_r == S_IDLE);

  a_inherent_len: assert property ( // RULE4
    DONE_OUT && RES_OUT.mode == AM_INH && !RES_OUT.use_two && !RES_OUT.mode_err |->
      RES_OUT.length == OPCODE_BYTES)
    else $error("inherent length wrong");

  a_immediate_len: assert property ( // RULE5
    DONE_OUT && RES_OUT.mode == AM_IMM && !RES_OUT.use_two && !RES_OUT.mode_err |->
      RES_OUT.length == OPCODE_BYTES + 3'h1)
    else $error("immediate length wrong");

  a_short_page_zero: assert property ( // RULE6
    DONE_OUT && !RES_OUT.mode_err && RES_OUT.mode inside {AM_DIR_S, AM_IND_S, AM_BIT_D, AM_BIT_I} |->
      RES_OUT.eff_addr[15:8] == PAGE_ZERO_HI)
    else $error("short form left page zero");

  a_short_idx_range: assert property ( // RULE11
    DONE_OUT && !RES_OUT.mode_err && RES_OUT.mode inside {AM_IDX_S, AM_INDX_S} |->
      RES_OUT.eff_addr <= SHORT_INDEXED_TOP)
    else $error("short indexed out of range");

  a_second_idx_len: assert property ( // RULE10
    DONE_OUT && !RES_OUT.mode_err && RES_OUT.mode == AM_IDX0 && RES_OUT.use_two |->
      RES_OUT.length == OPCODE_BYTES + 3'h1)
    else $error("second index length wrong");

  a_long_pair_read: assert property ( // RULE7
    take_w && req_ok && oag_extra(req_mode) == 2'h2 |->
      ##1 MEM_RD_OUT ##2 (MEM_RD_OUT && MEM_ADDR_OUT == $past(MEM_ADDR_OUT, 2) + 16'h0001))
    else $error("long operand not read as pair");

  a_rmw_long_refused: assert property ( // RULE3
    take_w && REQ_IN.cls == CL_RMW && REQ_IN.mode == AM_DIR_L |->
      ##2 (DONE_OUT && RES_OUT.mode_err))
    else $error("long form accepted for rmw");

  a_pointer_page0: assert property ( // RULE13
    MEM_RD_OUT && st_r inside {S_PT1, S_PT2} && mode_r != AM_IND_L && mode_r != AM_INDX_L |->
      MEM_ADDR_OUT[15:8] == PAGE_ZERO_HI)
    else $error("pointer read outside page zero");

  a_idx0_no_fetch: assert property ( // RULE9
    take_w && req_ok && req_mode == AM_IDX0 |-> ##1 !MEM_RD_OUT ##1 (DONE_OUT && !MEM_RD_OUT))
    else $error("no-offset indexed fetched a byte");

  c_long_direct: cover property (DONE_OUT && RES_OUT.mode == AM_DIR_L && !RES_OUT.mode_err);
  c_long_ind_idx: cover property (DONE_OUT && RES_OUT.mode == AM_INDX_L && RES_OUT.use_two);
  c_bitrel_ind: cover property (DONE_OUT && RES_OUT.mode == AM_BITREL_I && !RES_OUT.mode_err);
  c_mode_error: cover property (DONE_OUT && RES_OUT.mode_err);

endmodule // oag_core

// ===== oag_mem.sv
`timescale 1ns/100ps
module oag_mem (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic rd_in,
  input wire logic [15:0] addr_in,
  output logic [7:0] data_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] data_r;
  logic [7:0] data_nxt;

  // Background pattern so unwritten bytes never read as unknown
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hee;
    end
  end

  // Read data valid for one cycle only, then the bus toggles so stale bytes cannot pass
  always_comb begin
    data_nxt = rd_in ? mem[addr_in] : ~data_r;
  end

  // Data register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_r <= 8'h5a;
    end else begin
      data_r <= data_nxt;
    end
  end

  assign data_out = data_r;
endmodule // oag_mem

// ===== test_core_operand_address_generator.sv
`timescale 1ns/100ps
module test_core_operand_address_generator;
  import oag_pkg::*;
  logic clk, rst_n, start, mem_rd, busy, done;
  logic [7:0] mem_data;
  logic [15:0] mem_addr;
  oag_req_s req;
  oag_res_s res, res_q;
  int err_count = 0;
  int n_checks = 0;
  int cyc_q = 0;
  int tick = 0;

  // Clock generator
  initial clk = 1'b0;
  always #5 clk = ~clk;

  oag_core i_oag_core (.CLOCK_IN(clk), .RST_N_IN(rst_n), .START_IN(start), .REQ_IN(req), .MEM_DATA_IN(mem_data),
    .MEM_RD_OUT(mem_rd), .MEM_ADDR_OUT(mem_addr), .BUSY_OUT(busy), .DONE_OUT(done), .RES_OUT(res));
  oag_mem i_oag_mem (.clock_in(clk), .rst_n_in(rst_n), .rd_in(mem_rd), .addr_in(mem_addr), .data_out(mem_data));

  // Compare one value
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Final report and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Preload a memory byte
  task automatic put(input logic [15:0] a, input logic [7:0] v);
    i_oag_mem.mem[a] = v;
  endtask

  // One request, counting cycles from the take cycle (cycle 0) to the result pulse
  task automatic run(input oag_mode_e m, input oag_class_e c, input logic [7:0] pre, input logic [7:0] x,
                     input logic [7:0] y, input logic [15:0] na);
    @(posedge clk);
    start <= 1'b1;
    req <= '{mode: m, cls: c, prebyte: pre, ind_reg_one: x, ind_reg_two: y, next_addr: na};
    @(posedge clk);
    start <= 1'b0;
    #1;
    check("busy", 16'(busy), 16'h0001);
    cyc_q = 1;
    do begin
      @(posedge clk);
      #1;
      cyc_q++;
    end while (done !== 1'b1 && cyc_q < 20);
    check("done", 16'(done), 16'h0001);
    check("busy_end", 16'(busy), 16'h0000);
    res_q = res;
  endtask

  // Common result fields
  task automatic expect_res(input oag_mode_e m, input logic two, input logic er, input logic [2:0] len, input int cyc);
    check("mode", res_q.mode, m);
    check("use_two", res_q.use_two, two);
    check("mode_err", res_q.mode_err, er);
    check("length", res_q.length, len);
    check("cycles", 16'(cyc_q), 16'(cyc));
  endtask

  // Inherent and no-offset indexed forms
  task automatic t_no_bytes();
    run(AM_INH, CL_REG, NO_PREBYTE, 8'h11, 8'h22, 16'h0100);
    expect_res(AM_INH, 1'b0, 1'b0, 3'h1, 2);
    run(AM_INH, CL_RMW, SECOND_INDEX_PREBYTE, 8'h11, 8'h22, 16'h0100);
    expect_res(AM_INH, 1'b1, 1'b0, 3'h2, 2);
    run(AM_IDX0, CL_ALU, NO_PREBYTE, 8'h80, 8'hfe, 16'h0100);
    expect_res(AM_IDX0, 1'b0, 1'b0, 3'h1, 2);
    check("eff", res_q.eff_addr, 16'h0080);
    run(AM_IDX0, CL_ALU, SECOND_INDEX_PREBYTE, 8'h80, 8'hff, 16'h0100);
    expect_res(AM_IDX0, 1'b1, 1'b0, 3'h2, 2);
    check("eff", res_q.eff_addr, 16'h00ff);
  endtask

  // Immediate and direct forms
  task automatic t_direct();
    put(16'h1234, 8'ha5);
    run(AM_IMM, CL_ALU, NO_PREBYTE, 8'h00, 8'h00, 16'h1234);
    expect_res(AM_IMM, 1'b0, 1'b0, 3'h2, 4);
    check("operand", res_q.operand, 8'ha5);
    put(16'h0200, 8'hf0);
    run(AM_DIR_S, CL_RMW, NO_PREBYTE, 8'h00, 8'h00, 16'h0200);
    expect_res(AM_DIR_S, 1'b0, 1'b0, 3'h2, 4);
    check("eff", res_q.eff_addr, 16'h00f0);
    put(16'h0300, 8'hbe);
    put(16'h0301, 8'hef);
    run(AM_DIR_L, CL_ALU, NO_PREBYTE, 8'h00, 8'h00, 16'h0300);
    expect_res(AM_DIR_L, 1'b0, 1'b0, 3'h3, 6);
    check("eff", res_q.eff_addr, 16'hbeef);
  endtask

  // Short and long indexed forms, the first at the top of the short range
  task automatic t_indexed();
    put(16'h0400, 8'hff);
    run(AM_IDX_S, CL_RMW, NO_PREBYTE, 8'hff, 8'h00, 16'h0400);
    expect_res(AM_IDX_S, 1'b0, 1'b0, 3'h2, 4);
    check("eff", res_q.eff_addr, 16'h01fe);
    run(AM_IDX_S, CL_ALU, SECOND_INDEX_PREBYTE, 8'h00, 8'h10, 16'h0400);
    expect_res(AM_IDX_S, 1'b1, 1'b0, 3'h3, 4);
    check("eff", res_q.eff_addr, 16'h010f);
    put(16'h0500, 8'h12);
    put(16'h0501, 8'h00);
    run(AM_IDX_L, CL_ALU, NO_PREBYTE, 8'h34, 8'h00, 16'h0500);
    expect_res(AM_IDX_L, 1'b0, 1'b0, 3'h3, 6);
    check("eff", res_q.eff_addr, 16'h1234);
  endtask

  // Pointers fetched from page zero and, for the long pointer at FF, from 0100
  task automatic t_indirect();
    put(16'h0600, 8'h40);
    put(16'h0040, 8'h77);
    run(AM_DIR_S, CL_ALU, INDIRECT_PREBYTE, 8'h00, 8'h00, 16'h0600);
    expect_res(AM_IND_S, 1'b0, 1'b0, 3'h3, 6);
    check("eff", res_q.eff_addr, 16'h0077);
    put(16'h0700, 8'hff);
    put(16'h00ff, 8'hab);
    put(16'h0100, 8'hcd);
    run(AM_DIR_L, CL_ALU, INDIRECT_PREBYTE, 8'h00, 8'h00, 16'h0700);
    expect_res(AM_IND_L, 1'b0, 1'b0, 3'h3, 8);
    check("eff", res_q.eff_addr, 16'habcd);
    put(16'h0800, 8'h41);
    put(16'h0041, 8'hff);
    run(AM_IDX_S, CL_RMW, INDIRECT_PREBYTE, 8'hff, 8'h00, 16'h0800);
    expect_res(AM_INDX_S, 1'b0, 1'b0, 3'h3, 6);
    check("eff", res_q.eff_addr, 16'h01fe);
    put(16'h0900, 8'h42);
    put(16'h0042, 8'h12);
    put(16'h0043, 8'h30);
    run(AM_IDX_L, CL_ALU, SECOND_INDIRECT_PREBYTE, 8'h01, 8'h04, 16'h0900);
    expect_res(AM_INDX_L, 1'b1, 1'b0, 3'h3, 8);
    check("eff", res_q.eff_addr, 16'h1234);
  endtask

  // Relative and bit forms
  task automatic t_branch();
    put(16'h2000, 8'h80);
    run(AM_REL_D, CL_BRANCH, NO_PREBYTE, 8'h00, 8'h00, 16'h2000);
    expect_res(AM_REL_D, 1'b0, 1'b0, 3'h2, 4);
    check("target", res_q.branch_target, 16'h1f81);
    put(16'h2100, 8'h7f);
    run(AM_REL_D, CL_BRANCH, NO_PREBYTE, 8'h00, 8'h00, 16'h2100);
    check("target", res_q.branch_target, 16'h2180);
    put(16'h2200, 8'h50);
    put(16'h0050, 8'hfe);
    run(AM_REL_D, CL_BRANCH, INDIRECT_PREBYTE, 8'h00, 8'h00, 16'h2200);
    expect_res(AM_REL_I, 1'b0, 1'b0, 3'h3, 6);
    check("target", res_q.branch_target, 16'h21ff);
    put(16'h2300, 8'h33);
    run(AM_BIT_D, CL_BIT, NO_PREBYTE, 8'h00, 8'h00, 16'h2300);
    expect_res(AM_BIT_D, 1'b0, 1'b0, 3'h2, 4);
    check("eff", res_q.eff_addr, 16'h0033);
    put(16'h2400, 8'h60);
    put(16'h2401, 8'hfe);
    put(16'h0060, 8'h44);
    run(AM_BITREL_D, CL_BIT, INDIRECT_PREBYTE, 8'h00, 8'h00, 16'h2400);
    expect_res(AM_BITREL_I, 1'b0, 1'b0, 3'h4, 8);
    check("eff", res_q.eff_addr, 16'h0044);
    check("target", res_q.branch_target, 16'h2400);
    put(16'h2500, 8'h70);
    put(16'h0070, 8'h55);
    run(AM_BIT_D, CL_BIT, INDIRECT_PREBYTE, 8'h00, 8'h00, 16'h2500);
    expect_res(AM_BIT_I, 1'b0, 1'b0, 3'h3, 6);
    check("eff", res_q.eff_addr, 16'h0055);
    put(16'h2600, 8'h21);
    put(16'h2601, 8'h02);
    run(AM_BITREL_D, CL_BIT, NO_PREBYTE, 8'h00, 8'h00, 16'h2600);
    expect_res(AM_BITREL_D, 1'b0, 1'b0, 3'h3, 6);
    check("eff", res_q.eff_addr, 16'h0021);
    check("target", res_q.branch_target, 16'h2604);
  endtask

  // Combinations the instruction class or prebyte does not allow
  task automatic t_refused();
    oag_mode_e em [4] = '{AM_DIR_L, AM_IMM, AM_INH, AM_DIR_S};
    oag_class_e ec [4] = '{CL_RMW, CL_REG, CL_ALU, CL_ALU};
    logic [7:0] ep [4] = '{NO_PREBYTE, NO_PREBYTE, NO_PREBYTE, 8'h93};
    for (int i = 0; i < 4; i++) begin
      run(em[i], ec[i], ep[i], 8'h00, 8'h00, 16'h0300);
      check("mode_err", res_q.mode_err, 1'b1);
      check("cycles", 16'(cyc_q), 16'h0002);
    end
  endtask

  // Hang guard
  always @(posedge clk) begin
    tick++;
    if (tick == 2000) begin
      err_count++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    start = 1'b0;
    req = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_no_bytes();
    t_direct();
    t_indexed();
    t_indirect();
    t_branch();
    t_refused();
    wrap_up();
  end
endmodule // test_core_operand_address_generator
